// ### vip_consts.svh
// Overview of operation
// - Normal entry uses delivered handler address, never fixed.
// - Fast interrupts never fetch an address.
// - Both request inputs are active low.
// - Requests pass synchronizers unless bypass strap high.
// - Vector-valid synchronized unless its bypass high.
// - Controller presents word-aligned handler address bits.
// - Acknowledge raised only for normal interrupts.
// - Entry starts when normal request sampled low.
// - Capture vector when acknowledge and valid both high.
// - Acknowledge drops once vector captured.
// - Requests ignored while vector-valid is high.
// - Fast request ignored during normal entry.
// - Valid only with ready address, held until acknowledge low.
// - Address may change before valid rises.
// - Acknowledge low: stack priority, then clear valid; controller pulses vector_taken on the same edge that clears valid.
// - Release normal request no later than clearing valid.
// - Controller synchronizes acknowledge when clocks asynchronous.
// - Synchronous mode shrinks acknowledge and valid delays to one cycle.
// - Integrator ties request bypass low, valid bypass per mode.
`ifndef VIP_CONSTS_SVH
`define VIP_CONSTS_SVH

`define VIP_VEC_MSB 31
`define VIP_VEC_LSB 2
`define VIP_VEC_W 30
`define VIP_ADDR_W 32
`define VIP_SYNC_STAGES 3
`define VIP_REQ_N_RST 1'h1
`define VIP_ACK_RST 1'h0
`define VIP_VALID_RST 1'h0
`define VIP_VEC_RST 30'h0

`endif

// ### vip_pkg.sv
`include "vip_consts.svh"

package vip_pkg;

   typedef logic [`VIP_VEC_W-1:0] vip_vec_t;
   typedef logic [`VIP_ADDR_W-1:0] vip_addr_t;

   typedef enum logic [2:0] {
      VIP_C_IDLE = 3'h0,
      VIP_C_DECIDE = 3'h1,
      VIP_C_ACK = 3'h3,
      VIP_C_RELEASE = 3'h2,
      VIP_C_FAST = 3'h6
   } vip_core_state_t;

   typedef enum logic [1:0] {
      VIP_K_IDLE = 2'h0,
      VIP_K_VALID = 2'h1
   } vip_ctrl_state_t;

endpackage : vip_pkg

// ### vip_if.sv
`timescale 1ns/1ns
`default_nettype none

interface vip_if;
   import vip_pkg::*;

   logic fast_int_req_n;
   logic normal_int_req_n;
   logic vector_fetch_ack;
   logic vector_valid;
   vip_vec_t vector_bus;

   modport core (
      input fast_int_req_n,
      input normal_int_req_n,
      input vector_valid,
      input vector_bus,
      output vector_fetch_ack
   );

   modport ctrl (
      output fast_int_req_n,
      output normal_int_req_n,
      output vector_valid,
      output vector_bus,
      input vector_fetch_ack
   );

endinterface : vip_if

`default_nettype wire

// ### vip_sync.sv
`timescale 1ns/1ns
`default_nettype none

module vip_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control.
   input wire logic bypass,
   // Data.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // ************************************************************
   // Parameter check.
   // ************************************************************
   if (W < 1) begin : g_chk
      $error("vip_sync needs a width of at least one.");
   end

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;

   // ************************************************************
   // Three-stage chain; a bit changes once stages two and three agree.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Bypass leaves a single register stage.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= RST_VAL;
      end else if (bypass) begin
         q_reg <= d;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   assign q = q_reg;

endmodule : vip_sync

`default_nettype wire

// ### vip_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "vip_consts.svh"

module vip_ctrl (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link to the core.
   vip_if.ctrl link,
   // Clocking mode.
   input wire logic async_mode,
   // Prioritiser side.
   input wire logic normal_pending,
   input wire vip_pkg::vip_vec_t normal_vector,
   input wire logic fast_pending,
   output logic vector_taken,
   output vip_pkg::vip_vec_t taken_vector,
   output logic handshake_busy
);
   import vip_pkg::*;

   vip_ctrl_state_t state_reg;
   logic ack_s;
   logic valid_reg;
   vip_vec_t vec_reg;
   logic nreq_reg;
   logic freq_reg;
   logic block_reg;
   logic taken_reg;

   // ************************************************************
   // Acknowledge input stage.
   // ************************************************************
   vip_sync #(.W(1), .RST_VAL(`VIP_ACK_RST)) u_ack_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bypass(!async_mode),
      .d(link.vector_fetch_ack),
      .q(ack_s)
   );

   // ************************************************************
   // Handshake.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= VIP_K_IDLE;
         valid_reg <= `VIP_VALID_RST;
         vec_reg <= `VIP_VEC_RST;
         taken_reg <= 1'h0;
      end else begin
         taken_reg <= 1'h0;
         case (state_reg)
            VIP_K_IDLE: begin
               vec_reg <= normal_vector;
               if (ack_s) begin
                  valid_reg <= 1'h1;
                  state_reg <= VIP_K_VALID;
               end
            end
            VIP_K_VALID: begin
               if (!ack_s) begin
                  valid_reg <= 1'h0;
                  taken_reg <= 1'h1;
                  state_reg <= VIP_K_IDLE;
               end
            end
            default: begin
               valid_reg <= 1'h0;
               state_reg <= VIP_K_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Request outputs.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nreq_reg <= `VIP_REQ_N_RST;
         freq_reg <= `VIP_REQ_N_RST;
         block_reg <= 1'h0;
      end else begin
         block_reg <= taken_reg;
         freq_reg <= !fast_pending;
         if (state_reg == VIP_K_VALID && !ack_s) begin
            nreq_reg <= 1'h1;
         end else begin
            nreq_reg <= !(normal_pending && !taken_reg && !block_reg);
         end
      end
   end

   assign link.vector_valid = valid_reg;
   assign link.vector_bus = vec_reg;
   assign link.normal_int_req_n = nreq_reg;
   assign link.fast_int_req_n = freq_reg;
   assign vector_taken = taken_reg;
   assign taken_vector = vec_reg;
   assign handshake_busy = valid_reg;

endmodule : vip_ctrl

`default_nettype wire

// ### vip_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "vip_consts.svh"

module vip_core (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,

   // Link to the interrupt controller.
   vip_if.core link,

   // Synchronizer bypass straps.
   input wire logic int_req_sync_bypass,
   input wire logic vector_valid_sync_bypass,

   // Processor mask state.
   input wire logic irq_enable,
   input wire logic fiq_enable,

   // Entry outputs to the pipeline.
   output logic irq_entry,
   output logic fiq_entry,
   output vip_pkg::vip_addr_t handler_addr,
   output logic entry_busy
);
   import vip_pkg::*;

   // ************************************************************
   // Declarations.
   // ************************************************************
   vip_core_state_t state_reg;
   vip_core_state_t state_next;

   logic [1:0] req_n_s;
   logic fiq_n_s;
   logic irq_n_s;
   logic valid_s;

   logic fiq_pend;
   logic irq_pend;

   logic ack_reg;
   logic ack_next;
   vip_addr_t addr_reg;
   logic irq_entry_reg;
   logic fiq_entry_reg;
   logic busy_reg;
   logic [1:0] settle_reg;

   localparam logic [1:0] SETTLE_MAX = 2'(`VIP_SYNC_STAGES);

   // ************************************************************
   // Helper functions.
   // ************************************************************
   function automatic vip_addr_t vec_to_addr(input vip_vec_t v);
      vec_to_addr = {v, 2'h0};
   endfunction : vec_to_addr

   function automatic logic req_seen(input logic req_n, input logic en, input logic vld);
      req_seen = !req_n && en && !vld;
   endfunction : req_seen

   // ************************************************************
   // Input synchronizers.
   // ************************************************************
   vip_sync #(.W(2), .RST_VAL({`VIP_REQ_N_RST, `VIP_REQ_N_RST})) u_req_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bypass(int_req_sync_bypass),
      .d({link.fast_int_req_n, link.normal_int_req_n}),
      .q(req_n_s)
   );

   vip_sync #(.W(1), .RST_VAL(`VIP_VALID_RST)) u_valid_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bypass(vector_valid_sync_bypass),
      .d(link.vector_valid),
      .q(valid_s)
   );

   assign fiq_n_s = req_n_s[1];
   assign irq_n_s = req_n_s[0];

   // ************************************************************
   // Pending requests.
   // ************************************************************
   // Low level is a request; nothing is seen while valid stands high.
   assign fiq_pend = req_seen(fiq_n_s, fiq_enable, valid_s);
   assign irq_pend = req_seen(irq_n_s, irq_enable, valid_s);

   // ************************************************************
   // Entry state machine.
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      ack_next = ack_reg;
      case (state_reg)
         VIP_C_IDLE: begin
            ack_next = 1'h0;
            if (irq_pend || fiq_pend) begin
               state_next = VIP_C_DECIDE;
            end
         end
         VIP_C_DECIDE: begin
            if (fiq_pend) begin
               state_next = VIP_C_FAST;
            end else if (irq_pend) begin
               state_next = VIP_C_ACK;
               ack_next = 1'h1;
            end else begin
               state_next = VIP_C_IDLE;
            end
         end
         VIP_C_ACK: begin
            // Fast request is not looked at here.
            if (ack_reg && valid_s) begin
               state_next = VIP_C_RELEASE;
               ack_next = 1'h0;
            end
         end
         VIP_C_RELEASE: begin
            ack_next = 1'h0;
            if (!valid_s && (int_req_sync_bypass || settle_reg == SETTLE_MAX)) begin
               state_next = VIP_C_IDLE;
            end
         end
         VIP_C_FAST: begin
            ack_next = 1'h0;
            state_next = VIP_C_IDLE;
         end
         default: begin
            ack_next = 1'h0;
            state_next = VIP_C_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= VIP_C_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Request settle count.
   // ************************************************************
   // A request still inside the unbypassed chain must not be taken twice.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         settle_reg <= 2'h0;
      end else if (state_reg != VIP_C_RELEASE || valid_s) begin
         settle_reg <= 2'h0;
      end else if (settle_reg != SETTLE_MAX) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   // ************************************************************
   // Acknowledge output.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= `VIP_ACK_RST;
      end else begin
         ack_reg <= ack_next;
      end
   end

   // ************************************************************
   // Vector capture.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= {`VIP_VEC_RST, 2'h0};
      end else if (state_reg == VIP_C_ACK && ack_reg && valid_s) begin
         addr_reg <= vec_to_addr(link.vector_bus);
      end
   end

   // ************************************************************
   // Entry pulses.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_entry_reg <= 1'h0;
         fiq_entry_reg <= 1'h0;
      end else begin
         irq_entry_reg <= (state_reg == VIP_C_ACK) && ack_reg && valid_s;
         fiq_entry_reg <= (state_reg == VIP_C_DECIDE) && fiq_pend;
      end
   end

   // ************************************************************
   // Busy flag.
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'h0;
      end else begin
         busy_reg <= (state_next != VIP_C_IDLE);
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************
   assign link.vector_fetch_ack = ack_reg;
   assign irq_entry = irq_entry_reg;
   assign fiq_entry = fiq_entry_reg;
   assign handler_addr = addr_reg;
   assign entry_busy = busy_reg;

endmodule : vip_core

`default_nettype wire

// ### vip_sva.sv
`timescale 1ns/1ns
`default_nettype none
module vip_sva (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link signals.
   input wire logic fast_int_req_n,
   input wire logic normal_int_req_n,
   input wire logic vector_fetch_ack,
   input wire logic vector_valid,
   input wire vip_pkg::vip_vec_t vector_bus
);
   import vip_pkg::*;
   // ****
   // Handshake checks.
   // ****
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   a_ack_needs_req: assert property (
      $rose(vector_fetch_ack) |-> !normal_int_req_n && !vector_valid)
      else $error("ack rose without request");
   a_valid_after_ack: assert property ($rose(vector_valid) |-> vector_fetch_ack)
      else $error("valid rose without ack");
   a_bus_stable: assert property (
      vector_valid && $past(vector_valid) |-> $stable(vector_bus))
      else $error("vector moved while valid");
   a_valid_holds: assert property (vector_valid && vector_fetch_ack |=> vector_valid)
      else $error("valid dropped before ack low");
   a_ack_drops: assert property ($rose(vector_valid) |-> ##[1:8] !vector_fetch_ack)
      else $error("ack not dropped after valid");
   a_valid_answers: assert property (
      $rose(vector_fetch_ack) |-> ##[1:8] vector_valid)
      else $error("no valid after ack");
   a_valid_clears: assert property ($fell(vector_fetch_ack) |-> ##[1:8] !vector_valid)
      else $error("valid not cleared");
   a_req_released: assert property ($fell(vector_valid) |-> normal_int_req_n [*2])
      else $error("request not released");
   c_ack: cover property ($rose(vector_fetch_ack));
   c_done: cover property ($fell(vector_valid));
   c_fast: cover property ($fell(fast_int_req_n));
endmodule : vip_sva
`default_nettype wire

// ### vectored_irq_port_handshake_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module vectored_irq_port_handshake_tb_top;
   import vip_pkg::*;
   // ****
   // Signals and rows.
   // ****
   typedef struct {logic am; logic rb; logic vb; vip_vec_t vec; int lat;} vip_row_t;
   logic clk_sys = 1'h0;
   logic rst_n, async_mode, rq_byp, vl_byp, irq_enable, fiq_enable, irq_b, fiq_b;
   logic normal_pending, fast_pending, vector_taken, irq_entry, fiq_entry, entry_busy;
   logic hs_busy, busy_b;
   vip_vec_t normal_vector, taken_vector;
   vip_addr_t handler_addr, addr_b;
   int miscompares = 0;
   int check_count = 0;
   vip_row_t rows [4] = '{'{1'h1, 1'h0, 1'h0, 30'h3FFFFFFF, 0},
      '{1'h1, 1'h1, 1'h0, 30'h00000001, 0}, '{1'h0, 1'h0, 1'h1, 30'h2AAAAAAA, 2},
      '{1'h0, 1'h1, 1'h1, 30'h15555555, 2}};
   vip_if lk ();
   vip_if lk2 ();
   always #5 clk_sys = ~clk_sys;
   vip_core i_vip_core (.clk_sys, .rst_n, .link(lk), .int_req_sync_bypass(rq_byp),
      .vector_valid_sync_bypass(vl_byp), .irq_enable, .fiq_enable, .irq_entry,
      .fiq_entry, .handler_addr, .entry_busy);
   vip_ctrl i_vip_ctrl (.clk_sys, .rst_n, .link(lk), .async_mode, .normal_pending,
      .normal_vector, .fast_pending, .vector_taken, .taken_vector, .handshake_busy(hs_busy));
   vip_core i_vip_core_b (.clk_sys, .rst_n, .link(lk2), .int_req_sync_bypass(1'h1),
      .vector_valid_sync_bypass(1'h1), .irq_enable, .fiq_enable, .irq_entry(irq_b),
      .fiq_entry(fiq_b), .handler_addr(addr_b), .entry_busy(busy_b));
   vip_sva i_vip_sva (.clk_sys, .rst_n, .fast_int_req_n(lk.fast_int_req_n),
      .normal_int_req_n(lk.normal_int_req_n), .vector_fetch_ack(lk.vector_fetch_ack),
      .vector_valid(lk.vector_valid), .vector_bus(lk.vector_bus));
   // ****
   // Tasks.
   // ****
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_lvl(ref logic s, input logic lvl);
      int n = 0;
      while (s !== lvl && n < 100) begin
         step();
         n++;
      end
      chk(s, lvl);
   endtask : wait_lvl
   task automatic do_reset();
      rst_n = 1'h0;
      repeat (8) step();
      rst_n = 1'h1;
      step();
      chk({lk.vector_fetch_ack, lk.vector_valid, lk.normal_int_req_n, lk.fast_int_req_n,
         hs_busy}, 5'h6);
      chk(handler_addr, 32'h0);
   endtask : do_reset
   task automatic irq_run(input vip_vec_t v, input int lat, input logic fmid);
      int n = 0, w = 0, ent = 0, tk = 0, fq = 0;
      normal_vector = v;
      normal_pending = 1'h1;
      while (!(tk > 0 && entry_busy === 1'h0 && (fq > 0 || !fmid)) && n < 300) begin
         step();
         n++;
         if (lk.vector_fetch_ack === 1'h1 && lk.vector_valid === 1'h0) w++;
         if (lk.vector_fetch_ack === 1'h1 && fmid) fast_pending = 1'h1;
         if (fiq_entry === 1'h1) begin
            chk(ent, 1);
            fq++;
            fast_pending = 1'h0;
         end
         if (irq_entry === 1'h1) begin
            ent++;
            chk(handler_addr, {v, 2'h0});
            chk(hs_busy, 1'h1);
         end
         if (vector_taken === 1'h1) begin
            tk++;
            normal_pending = 1'h0;
            chk(taken_vector, v);
            chk(lk.normal_int_req_n, 1'h1);
         end
      end
      chk(ent, 1);
      chk(tk, 1);
      chk(fq > 0, fmid);
      if (lat > 0) chk(w, lat);
      repeat (8) step();
      chk(entry_busy, 1'h0);
   endtask : irq_run
   task automatic test_done();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   // ****
   // Sequence.
   // ****
   initial begin
      rst_n = 1'h0;
      {async_mode, rq_byp, vl_byp, irq_enable, fiq_enable} = 5'h0F;
      {normal_pending, fast_pending} = 2'h0;
      normal_vector = 30'h0;
      {lk2.fast_int_req_n, lk2.normal_int_req_n, lk2.vector_valid} = 3'h6;
      lk2.vector_bus = 30'h0ABCDEF0;
      foreach (rows[i]) begin
         {async_mode, rq_byp, vl_byp} = {rows[i].am, rows[i].rb, rows[i].vb};
         do_reset();
         irq_run(rows[i].vec, rows[i].lat, 1'h0);
      end
      irq_run(30'h01234567, 2, 1'h1);
      normal_vector = 30'h3C3C3C3C;
      {normal_pending, fast_pending} = 2'h3;
      wait_lvl(fiq_entry, 1'h1);
      chk(lk.vector_fetch_ack, 1'h0);
      fast_pending = 1'h0;
      repeat (4) step();
      irq_run(30'h3C3C3C3C, 0, 1'h0);
      normal_pending = 1'h1;
      wait_lvl(lk.vector_fetch_ack, 1'h1);
      normal_pending = 1'h0;
      do_reset();
      {lk2.normal_int_req_n, lk2.fast_int_req_n, lk2.vector_valid} = 3'h1;
      repeat (10) begin
         step();
         chk({lk2.vector_fetch_ack, fiq_b}, 2'h0);
      end
      {lk2.vector_valid, lk2.fast_int_req_n} = 2'h1;
      wait_lvl(lk2.vector_fetch_ack, 1'h1);
      lk2.vector_valid = 1'h1;
      wait_lvl(irq_b, 1'h1);
      chk(addr_b, {lk2.vector_bus, 2'h0});
      chk(lk2.vector_fetch_ack, 1'h0);
      chk(busy_b, 1'h1);
      lk2.normal_int_req_n = 1'h1;
      repeat (3) step();
      lk2.vector_valid = 1'h0;
      repeat (8) step();
      chk(busy_b, 1'h0);
      test_done();
   end
   initial begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule : vectored_irq_port_handshake_tb_top
`default_nettype wire
